//--- pio_ports.sv
// Port one (8-bit) and port two (3-bit) parallel I/O with SFR access.
// Assumes the CPU core supplies bus states, address and strobes on sys_clk.
// Operation
// RULE1: Software avoids read-modify-write on write-only registers and interrupt latches.
// RULE2: Software never touches reserved addresses or forbidden directions.
// RULE3: Outputs are held in latches; inputs are sampled, never latched.
// RULE4: Port reads sample pin levels in the first bus state.
// RULE5: Port writes change the driven output in the second bus state.
// RULE6: Port one is eight bits; segment select one makes pin a segment.
// RULE7: Inputs or alternates need latch one and segment select zero.
// RULE8: General output needs segment select cleared to zero.
// RULE9: Reset sets all port one and port two latch bits to one.
// RULE10: Latch and pin input sit at separate addresses per port.
// RULE11: Pin input read of a segment bit is undefined.
// RULE12: Port two is three bits; inputs or alternates need latch one.
// RULE13: Dual-clock mode gives upper port two pins to the slow oscillator.
// RULE14: Falling edge on output-driven port two bit zero sets interrupt.
// RULE15: Port two reads define bits 2..0 only; bits 7..3 undefined.
// RULE16: In stop mode port two bit zero is high-impedance regardless.
// RULE17: Software should use port two bit zero only as input.
// RULE18: SFRs occupy the lowest sixty-four byte addresses.
// RULE19: Writes to a pin input register are ignored.
// RULE20: A latch one on a non-segment bit is never driven low.
module pio_ports
  import pio_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic first_bus_state,
  input wire logic second_bus_state,
  input wire logic [11:0] bus_addr,
  input wire logic bus_read,
  input wire logic bus_write,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  input wire logic global_output_enable,
  input wire logic stop_mode,
  input wire logic dual_clock_mode,
  input wire logic [7:0] port_one_in,
  output logic [7:0] port_one_out,
  output logic [7:0] port_one_oe,
  output logic [7:0] segment_enable,
  input wire logic [2:0] port_two_in,
  output logic [2:0] port_two_out,
  output logic [2:0] port_two_oe,
  output logic port_two_bit_zero_fall,
  output logic osc_pins_claimed
);

  logic [7:0] port_one_output_latch_q;
  logic [2:0] port_two_output_latch_q;
  logic [7:0] port_one_segment_select_q;
  logic [7:0] bus_rdata_q;
  logic [7:0] port_one_out_q;
  logic [7:0] port_one_oe_q;
  logic [7:0] segment_enable_q;
  logic [2:0] port_two_out_q;
  logic [2:0] port_two_oe_q;
  logic port_two_bit_zero_fall_q;
  logic osc_pins_claimed_q;
  logic bit_zero_level_q;
  logic sfr_hit;
  logic [7:0] port_one_drive_d;
  logic [2:0] port_two_drive_d;
  logic [2:0] port_two_oe_d;

  pio_sync_if sync_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  pio_pin_sync u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .port_one_raw(port_one_in),
    .port_two_raw(port_two_in),
    .sync(sync_bus.source)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address decode: only the low SFR window responds
  assign sfr_hit = (bus_addr[11:6] == 6'h00); // RULE18

  // Output latches, written in the second bus state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      port_one_output_latch_q <= port_one_latch_reset; // RULE9
      port_two_output_latch_q <= port_two_latch_reset; // RULE9
    end else if (bus_write && second_bus_state && sfr_hit) begin // RULE5
      if (bus_addr[7:0] == port_one_output_latch_offset) begin
        port_one_output_latch_q <= bus_wdata; // RULE3
      end
      if (bus_addr[7:0] == port_two_output_latch_offset) begin
        port_two_output_latch_q <= bus_wdata[2:0]; // RULE12
      end
    end
  end

  // Segment select register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      port_one_segment_select_q <= port_one_segment_reset;
    end else if (bus_write && second_bus_state && sfr_hit
                 && bus_addr[7:0] == port_one_segment_select_offset) begin
      port_one_segment_select_q <= bus_wdata; // RULE6
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, pins sampled in the first bus state; pin registers are
  // read-only so writes to them match no latch above
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_rdata_q <= 8'h00;
    end else if (bus_read && first_bus_state) begin // RULE4
      bus_rdata_q <= 8'h00;
      if (sfr_hit) begin
        unique case (bus_addr[7:0])
          port_one_output_latch_offset: begin
            bus_rdata_q <= port_one_output_latch_q; // RULE10
          end
          port_two_output_latch_offset: begin
            bus_rdata_q <= {undefined_fill[7:3], port_two_output_latch_q}; // RULE15
          end
          port_one_pin_input_offset: begin
            // Segment bits read as fill
            bus_rdata_q <= (sync_bus.port_one_level & ~port_one_segment_select_q)
                           | (undefined_fill & port_one_segment_select_q); // RULE11
          end
          port_two_pin_input_offset: begin
            bus_rdata_q <= {undefined_fill[7:3], sync_bus.port_two_level}; // RULE15
          end
          port_one_segment_select_offset: begin
            bus_rdata_q <= port_one_segment_select_q;
          end
          default: begin
            bus_rdata_q <= 8'h00;
          end
        endcase
      end
    end
  end
  // Writes to pin input offsets are dropped by decode above: RULE19

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive: open-drain style, latch one releases the pin
  always_comb begin
    port_one_drive_d = ~port_one_output_latch_q & ~port_one_segment_select_q; // RULE20
    port_two_drive_d = ~port_two_output_latch_q;
    if (!global_output_enable) begin
      port_one_drive_d = 8'h00;
      port_two_drive_d = 3'h0;
    end
    port_two_oe_d = port_two_drive_d;
    if (dual_clock_mode) begin
      port_two_oe_d[2:1] = 2'h0; // RULE13
    end
    if (stop_mode) begin
      port_two_oe_d[0] = 1'b0; // RULE16
    end
  end

  // Registered pin outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      port_one_out_q <= 8'h00;
      port_one_oe_q <= 8'h00;
      segment_enable_q <= 8'h00;
      port_two_out_q <= 3'h0;
      port_two_oe_q <= 3'h0;
      osc_pins_claimed_q <= 1'b0;
    end else begin
      port_one_out_q <= 8'h00;
      port_one_oe_q <= port_one_drive_d;
      segment_enable_q <= port_one_segment_select_q; // RULE6
      port_two_out_q <= 3'h0;
      port_two_oe_q <= port_two_oe_d;
      osc_pins_claimed_q <= dual_clock_mode; // RULE13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Falling edge on bit zero, seen from the pin even when self-driven
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bit_zero_level_q <= 1'b1;
      port_two_bit_zero_fall_q <= 1'b0;
    end else begin
      bit_zero_level_q <= sync_bus.port_two_level[0];
      port_two_bit_zero_fall_q <= bit_zero_level_q & ~sync_bus.port_two_level[0]; // RULE14
    end
  end

  assign bus_rdata = bus_rdata_q;
  assign port_one_out = port_one_out_q;
  assign port_one_oe = port_one_oe_q;
  assign segment_enable = segment_enable_q;
  assign port_two_out = port_two_out_q;
  assign port_two_oe = port_two_oe_q;
  assign port_two_bit_zero_fall = port_two_bit_zero_fall_q;
  assign osc_pins_claimed = osc_pins_claimed_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks: reset and write timing
  a_reset_latch_ones: assert property (@(posedge sys_clk) // RULE9
    $past(rst) |-> port_one_output_latch_q == port_one_latch_reset
    && port_two_output_latch_q == port_two_latch_reset)
    else $error("latches not all ones after reset");
  a_reset_quiet: assert property (@(posedge sys_clk) // RULE9
    $past(rst) |-> port_one_segment_select_q == port_one_segment_reset
    && port_one_oe == 8'h00 && port_two_oe == 3'h0)
    else $error("select or drive not cleared by reset");
  a_write_in_s2: assert property (@(posedge sys_clk) disable iff (rst) // RULE5
    !(bus_write && second_bus_state) |=> $stable(port_one_output_latch_q))
    else $error("port one latch changed outside second bus state");
  a_write_takes_data: assert property (@(posedge sys_clk) disable iff (rst) // RULE3
    bus_write && second_bus_state && bus_addr == {4'h0, port_one_output_latch_offset}
    |=> port_one_output_latch_q == $past(bus_wdata))
    else $error("port one write lost");
  a_p2_write_data: assert property (@(posedge sys_clk) disable iff (rst) // RULE12
    bus_write && second_bus_state && bus_addr == {4'h0, port_two_output_latch_offset}
    |=> port_two_output_latch_q == $past(bus_wdata[2:0]))
    else $error("port two write lost");
  a_seg_write: assert property (@(posedge sys_clk) disable iff (rst) // RULE6
    bus_write && second_bus_state && bus_addr == {4'h0, port_one_segment_select_offset}
    |=> port_one_segment_select_q == $past(bus_wdata))
    else $error("segment select write lost");
  a_pin_wr_ignored: assert property (@(posedge sys_clk) disable iff (rst) // RULE19
    bus_write && (bus_addr == {4'h0, port_one_pin_input_offset}
    || bus_addr == {4'h0, port_two_pin_input_offset})
    |=> $stable(port_one_output_latch_q) && $stable(port_two_output_latch_q)
    && $stable(port_one_segment_select_q))
    else $error("pin input write changed state");

  ////////////////////////////////////////////////////////////////////////////
  // Checks: read path; pin reads compare with synchronised levels, raw pins may settle
  a_read_in_s1: assert property (@(posedge sys_clk) disable iff (rst) // RULE4
    !(bus_read && first_bus_state) |=> $stable(bus_rdata_q))
    else $error("read data changed outside first bus state");
  a_latch_read: assert property (@(posedge sys_clk) disable iff (rst) // RULE10
    bus_read && first_bus_state && bus_addr == {4'h0, port_one_output_latch_offset}
    |=> bus_rdata == $past(port_one_output_latch_q))
    else $error("latch readback wrong");
  a_p2_latch_read: assert property (@(posedge sys_clk) disable iff (rst) // RULE10
    bus_read && first_bus_state && bus_addr == {4'h0, port_two_output_latch_offset}
    |=> bus_rdata[2:0] == $past(port_two_output_latch_q))
    else $error("port two latch readback wrong");
  a_seg_read: assert property (@(posedge sys_clk) disable iff (rst) // RULE6
    bus_read && first_bus_state && bus_addr == {4'h0, port_one_segment_select_offset}
    |=> bus_rdata == $past(port_one_segment_select_q))
    else $error("segment select readback wrong");
  a_pin_read_live: assert property (@(posedge sys_clk) disable iff (rst) // RULE10
    bus_read && first_bus_state && bus_addr == {4'h0, port_one_pin_input_offset}
    |=> (bus_rdata & ~$past(port_one_segment_select_q))
    == ($past(sync_bus.port_one_level) & ~$past(port_one_segment_select_q)))
    else $error("port one pin read not live");
  a_seg_read_fill: assert property (@(posedge sys_clk) disable iff (rst) // RULE11
    bus_read && first_bus_state && bus_addr == {4'h0, port_one_pin_input_offset}
    |=> (bus_rdata & $past(port_one_segment_select_q))
    == (undefined_fill & $past(port_one_segment_select_q)))
    else $error("segment bit read not filled");
  a_p2_pin_read: assert property (@(posedge sys_clk) disable iff (rst) // RULE10
    bus_read && first_bus_state && bus_addr == {4'h0, port_two_pin_input_offset}
    |=> bus_rdata[2:0] == $past(sync_bus.port_two_level))
    else $error("port two pin read not live");
  a_p2_upper_zero: assert property (@(posedge sys_clk) disable iff (rst) // RULE15
    bus_read && first_bus_state && bus_addr == {4'h0, port_two_pin_input_offset}
    |=> bus_rdata[7:3] == undefined_fill[7:3])
    else $error("port two upper read bits not filled");
  a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (rst) // RULE18
    bus_read && first_bus_state && bus_addr[11:6] != 6'h00 |=> bus_rdata == 8'h00)
    else $error("read above the register window not zero");

  ////////////////////////////////////////////////////////////////////////////
  // Checks: pin drive, only ever pulled low
  a_stop_hiz: assert property (@(posedge sys_clk) disable iff (rst) // RULE16
    stop_mode |=> !port_two_oe[0])
    else $error("bit zero driven in stop mode");
  a_one_not_driven: assert property (@(posedge sys_clk) disable iff (rst) // RULE20
    port_one_output_latch_q[0] |=> !port_one_oe[0])
    else $error("latch one bit driven low");
  a_p2_one_not_driven: assert property (@(posedge sys_clk) disable iff (rst) // RULE20
    port_two_output_latch_q[0] |=> !port_two_oe[0])
    else $error("port two latch one bit driven low");
  a_global_off: assert property (@(posedge sys_clk) disable iff (rst) // RULE20
    !global_output_enable |=> port_one_oe == 8'h00 && port_two_oe == 3'h0)
    else $error("pins driven while outputs disabled");
  a_low_drive_only: assert property (@(posedge sys_clk) disable iff (rst) // RULE20
    port_one_out == 8'h00 && port_two_out == 3'h0)
    else $error("pin driven high");
  a_seg_not_driven: assert property (@(posedge sys_clk) disable iff (rst) // RULE6
    (port_one_oe & segment_enable) == 8'h00)
    else $error("segment pin also driven as port");
  a_segment_follow: assert property (@(posedge sys_clk) disable iff (rst) // RULE6
    ##1 segment_enable == $past(port_one_segment_select_q))
    else $error("segment enable not following select");
  a_osc_release: assert property (@(posedge sys_clk) disable iff (rst) // RULE13
    dual_clock_mode |=> port_two_oe[2:1] == 2'h0)
    else $error("oscillator pins driven in dual-clock mode");
  a_osc_flag: assert property (@(posedge sys_clk) disable iff (rst) // RULE13
    dual_clock_mode |=> osc_pins_claimed)
    else $error("oscillator pins not claimed in dual-clock mode");

  ////////////////////////////////////////////////////////////////////////////
  // Checks: bit zero falling-edge pulse
  a_fall_flag: assert property (@(posedge sys_clk) disable iff (rst) // RULE14
    port_two_bit_zero_fall |-> $past(bit_zero_level_q) && !bit_zero_level_q)
    else $error("fall flag without falling edge");
  a_fall_sets: assert property (@(posedge sys_clk) disable iff (rst) // RULE14
    bit_zero_level_q && !sync_bus.port_two_level[0] |=> port_two_bit_zero_fall)
    else $error("falling edge on bit zero missed");
  a_fall_single: assert property (@(posedge sys_clk) disable iff (rst) // RULE14
    port_two_bit_zero_fall |=> !port_two_bit_zero_fall)
    else $error("fall pulse longer than one cycle");
endmodule

//--- pio_pkg.sv
// Package for the port one / port two parallel I/O block.
// Assumes an 8-bit SFR bus from the CPU core on sys_clk.
package pio_pkg;
  localparam logic [7:0] port_one_output_latch_offset = 8'h01;
  localparam logic [7:0] port_two_output_latch_offset = 8'h02;
  localparam logic [7:0] port_one_pin_input_offset = 8'h08;
  localparam logic [7:0] port_two_pin_input_offset = 8'h09;
  localparam logic [7:0] port_one_segment_select_offset = 8'h29;
  localparam logic [7:0] sfr_top_offset = 8'h3f;
  localparam logic [7:0] port_one_latch_reset = 8'hff;
  localparam logic [2:0] port_two_latch_reset = 3'h7;
  localparam logic [7:0] port_one_segment_reset = 8'h00;
  localparam int port_one_width = 8;
  localparam int port_two_width = 3;
  // Filler shown in undefined read bits
  localparam logic [7:0] undefined_fill = 8'h00;
endpackage

//--- pio_sync_if.sv
// Interface carrying synchronised pin levels into the port logic.
// Assumes both ends run on sys_clk.
interface pio_sync_if;
  logic [7:0] port_one_level;
  logic [2:0] port_two_level;
  modport source (output port_one_level, output port_two_level);
  modport sink (input port_one_level, input port_two_level);
endinterface

//--- pio_pin_sync.sv
// Two-stage synchroniser for the port one and port two pin inputs.
// Assumes raw pin levels arrive asynchronously to sys_clk.
module pio_pin_sync (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] port_one_raw,
  input wire logic [2:0] port_two_raw,
  pio_sync_if.source sync
);
  logic [10:0] stage1_q;
  logic [10:0] stage2_q;

  // First flop feeds only the second
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stage1_q <= 11'h7ff;
      stage2_q <= 11'h7ff;
    end else begin
      stage1_q <= {port_two_raw, port_one_raw};
      stage2_q <= stage1_q;
    end
  end

  assign sync.port_one_level = stage2_q[7:0];
  assign sync.port_two_level = stage2_q[10:8];
endmodule

//--- pio_pin_model.sv
// Far-side model: LCD segment driver, port output drive and external drive levels.
// Assumes open-drain port outputs, sampled asynchronously by the block.
module pio_pin_model (
  input wire logic sys_clk,
  input wire logic [7:0] port_one_out,
  input wire logic [7:0] port_one_oe,
  input wire logic [7:0] segment_enable,
  input wire logic [2:0] port_two_out,
  input wire logic [2:0] port_two_oe,
  input wire logic [7:0] ext_one,
  input wire logic [2:0] ext_two,
  output logic [7:0] port_one_pin,
  output logic [2:0] port_two_pin
);
  logic [7:0] lcd_q = 8'h00;
  ////////////////////////////////////////////////////////////////////////////
  // LCD waveform, bits 0, 2, 5 and 7 toggle every cycle while bits 1, 3, 4 and 6 stay low
  always_ff @(posedge sys_clk) begin
    lcd_q <= ~lcd_q ^ 8'h5a;
  end
  // Segment pins follow the LCD, driven pins take the port output, other pins the external level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      port_one_pin[i] = segment_enable[i] ? lcd_q[i]
                      : (port_one_oe[i] ? port_one_out[i] : ext_one[i]);
    end
    port_two_pin = (port_two_oe & port_two_out) | (~port_two_oe & ext_two);
  end
endmodule

//--- parallel_io_ports_one_two_test.sv
// Self-checking bench for the port one / port two block.
// Assumes the pin model of pio_pin_model.sv on the far side.
module parallel_io_ports_one_two_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, rst = 1'b1, first_bus_state = 1'b0, second_bus_state = 1'b0;
  logic bus_read = 1'b0, bus_write = 1'b0, global_output_enable = 1'b1;
  logic stop_mode = 1'b0, dual_clock_mode = 1'b0, port_two_bit_zero_fall, osc_pins_claimed;
  logic [11:0] bus_addr = 12'h000;
  logic [7:0] bus_wdata = 8'h00, bus_rdata, port_one_pin, port_one_out, port_one_oe;
  logic [7:0] segment_enable, ext_one = 8'hf3;
  logic [2:0] port_two_pin, port_two_out, port_two_oe, ext_two = 3'h7;
  logic seen;
  int fail_count = 0;
  int checked = 0;
  pio_ports pio_ports_i (.sys_clk(sys_clk), .rst(rst), .first_bus_state(first_bus_state),
    .second_bus_state(second_bus_state), .bus_addr(bus_addr), .bus_read(bus_read),
    .bus_write(bus_write), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .global_output_enable(global_output_enable), .stop_mode(stop_mode),
    .dual_clock_mode(dual_clock_mode), .port_one_in(port_one_pin),
    .port_one_out(port_one_out), .port_one_oe(port_one_oe), .segment_enable(segment_enable),
    .port_two_in(port_two_pin), .port_two_out(port_two_out), .port_two_oe(port_two_oe),
    .port_two_bit_zero_fall(port_two_bit_zero_fall), .osc_pins_claimed(osc_pins_claimed));
  pio_pin_model pio_pin_model_i (.sys_clk(sys_clk), .port_one_out(port_one_out),
    .port_one_oe(port_one_oe), .segment_enable(segment_enable), .port_two_out(port_two_out),
    .port_two_oe(port_two_oe), .ext_one(ext_one), .ext_two(ext_two),
    .port_one_pin(port_one_pin), .port_two_pin(port_two_pin));
  //////////////////////////////////////////////////////////////////////////////
  // Clock, 50 ns period
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  // Compare one value, count it
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One bus cycle with explicit strobes and bus-state markers
  task automatic bus_op(input logic [11:0] a, input logic [7:0] d, input logic rd,
                        input logic wr, input logic s1, input logic s2);
    @(negedge sys_clk);
    bus_addr = a;
    bus_wdata = d;
    bus_read = rd;
    bus_write = wr;
    first_bus_state = s1;
    second_bus_state = s2;
    @(negedge sys_clk);
    bus_read = 1'b0;
    bus_write = 1'b0;
    first_bus_state = 1'b0;
    second_bus_state = 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus_op(a, d, 1'b0, 1'b1, 1'b0, 1'b1);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string name);
    bus_op(a, 8'h00, 1'b1, 1'b0, 1'b1, 1'b0);
    @(negedge sys_clk);
    chk(name, exp, bus_rdata);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Verdict and end of run
  task automatic summarize();
    if (fail_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Hang guard
  initial begin
    #(4000 * 50);
    fail_count++;
    summarize();
  end
  // Test sequence
  initial begin
    idle(12);
    rst = 1'b0;
    rd(12'h001, 8'hff, "p1_latch_reset");
    rd(12'h002, 8'h07, "p2_latch_reset");
    rd(12'h029, 8'h00, "p1_seg_reset");
    chk("p1_oe_reset", 8'h00, port_one_oe);
    wr(12'h001, 8'h55);
    idle(2);
    chk("p1_oe_write", 8'haa, port_one_oe);
    bus_op(12'h001, 8'h00, 1'b0, 1'b1, 1'b0, 1'b0);
    idle(2);
    chk("p1_oe_no_s2", 8'haa, port_one_oe);
    rd(12'h001, 8'h55, "p1_latch");
    bus_op(12'h002, 8'h00, 1'b1, 1'b0, 1'b0, 1'b0);
    idle(1);
    chk("rdata_no_s1", 8'h55, bus_rdata);
    idle(3);
    rd(12'h008, 8'h55 & 8'hf3, "p1_pins");
    ext_one = 8'hff;
    idle(3);
    rd(12'h008, 8'h55, "p1_pins_change");
    wr(12'h029, 8'h0f);
    idle(2);
    chk("seg_enable", 8'h0f, segment_enable);
    chk("p1_oe_seg", 8'ha0, port_one_oe);
    rd(12'h029, 8'h0f, "p1_seg");
    idle(2);
    rd(12'h008, 8'h50, "p1_pins_seg");
    wr(12'h008, 8'h00);
    idle(2);
    rd(12'h001, 8'h55, "p1_pin_wr_ignored");
    chk("p1_oe_pin_wr", 8'ha0, port_one_oe);
    rd(12'h000, 8'h00, "reserved_read");
    rd(12'h041, 8'h00, "above_sfr_read");
    global_output_enable = 1'b0;
    idle(2);
    chk("p1_oe_global_off", 8'h00, port_one_oe);
    global_output_enable = 1'b1;
    ext_two = 3'h7;
    wr(12'h002, 8'hfa);
    seen = 1'b0;
    repeat (8) begin
      @(negedge sys_clk);
      seen = seen | (port_two_bit_zero_fall === 1'b1);
    end
    chk("p2_fall_pulse", 8'h01, {7'h00, seen});
    chk("p2_oe", 8'h05, {5'h00, port_two_oe});
    rd(12'h002, 8'h02, "p2_latch");
    rd(12'h009, 8'h02, "p2_pins");
    stop_mode = 1'b1;
    idle(2);
    chk("p2_oe_stop", 8'h04, {5'h00, port_two_oe});
    idle(2);
    rd(12'h009, 8'h03, "p2_pins_stop");
    dual_clock_mode = 1'b1;
    idle(2);
    chk("p2_oe_dual", 8'h00, {5'h00, port_two_oe});
    chk("osc_claimed", 8'h01, {7'h00, osc_pins_claimed});
    dual_clock_mode = 1'b0;
    stop_mode = 1'b0;
    idle(2);
    chk("p2_oe_single", 8'h05, {5'h00, port_two_oe});
    chk("p1_out", 8'h00, port_one_out);
    chk("p2_out", 8'h00, {5'h00, port_two_out});
    // Mid-run reset brings every latch back to ones
    rst = 1'b1;
    idle(3);
    rst = 1'b0;
    rd(12'h001, 8'hff, "p1_latch_rst2");
    rd(12'h002, 8'h07, "p2_latch_rst2");
    rd(12'h029, 8'h00, "p1_seg_rst2");
    chk("p1_oe_rst2", 8'h00, port_one_oe);
    // Port one as plain input: latch one, segment select zero
    wr(12'h029, 8'h00);
    wr(12'h001, 8'hff);
    ext_one = 8'h3c;
    idle(3);
    rd(12'h008, 8'h3c, "p1_pins_input");
    // Port two bit zero as external interrupt input
    wr(12'h002, 8'h07);
    ext_two = 3'h6;
    seen = 1'b0;
    repeat (8) begin
      @(negedge sys_clk);
      seen = seen | (port_two_bit_zero_fall === 1'b1);
    end
    chk("p2_fall_input", 8'h01, {7'h00, seen});
    rd(12'h009, 8'h06, "p2_pins_input");
    summarize();
  end
endmodule
